// >>> rtl/nand_host_consts.svh
`ifndef NAND_HOST_CONSTS_SVH
`define NAND_HOST_CONSTS_SVH

// ----------------------------------------------------------------------
// Opcodes placed on the shared byte lanes during command cycles
// ----------------------------------------------------------------------
`define NAND_OP_RESET 8'hFF
`define NAND_OP_STATUS 8'h70
`define NAND_OP_STATUS_ENH 8'h78
`define NAND_OP_READ_ID 8'h90
`define NAND_OP_PARAM_PAGE 8'hEC
`define NAND_OP_UNIQUE_ID 8'hED
`define NAND_OP_GET_FEAT 8'hEE
`define NAND_OP_SET_FEAT 8'hEF
`define NAND_OP_READ 8'h00
`define NAND_OP_READ_CONF 8'h30
`define NAND_OP_COPY_CONF 8'h35
`define NAND_OP_RAND_OUT 8'h05
`define NAND_OP_RAND_OUT_CONF 8'hE0
`define NAND_OP_RAND_IN 8'h85
`define NAND_OP_PROGRAM 8'h80
`define NAND_OP_REPROGRAM 8'h8B
`define NAND_OP_PROG_CONF 8'h10
`define NAND_OP_PROG_MID 8'h11
`define NAND_OP_ERASE 8'h60
`define NAND_OP_ERASE_CONF 8'hD0

// ----------------------------------------------------------------------
// Address framing
// ----------------------------------------------------------------------
`define NAND_ADDR_ZERO 3'h0
`define NAND_ADDR_ONE 3'h1
`define NAND_ADDR_COL 3'h2
`define NAND_ADDR_ROW 3'h3
`define NAND_ROW_START 3'h2
`define NAND_FEATURE_BYTES 13'h0004

// ----------------------------------------------------------------------
// Bus cycle phases and turnaround timing
// ----------------------------------------------------------------------
`define NAND_PH_SETUP 2'h0
`define NAND_PH_WE_HIGH 2'h3
`define NAND_PH_SAMPLE 2'h3
`define NAND_CLK_MHZ 20
`define NAND_TURN_NS 100
`define NAND_TURN_CYC (((`NAND_TURN_NS * `NAND_CLK_MHZ) + 999) / 1000)

`endif

// >>> rtl/nand_host_pkg.sv
package nand_host_pkg;

  // Operations a user may request from the controller.
  typedef enum logic [4:0] {
    OP_RESET, OP_STATUS, OP_STATUS_ENH, OP_READ_ID, OP_PARAM_PAGE,
    OP_UNIQUE_ID, OP_GET_FEAT, OP_SET_FEAT, OP_READ_MODE, OP_PAGE_READ,
    OP_COPY_READ, OP_RAND_OUT, OP_RAND_IN, OP_PROGRAM, OP_REPROGRAM,
    OP_COPY_PROGRAM, OP_ERASE, OP_RAW
  } op_type;

  // Sequencer states of the controller.
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_DIN, ST_CONF, ST_TURN, ST_WAIT, ST_DOUT
  } state_type;

endpackage : nand_host_pkg

// >>> rtl/nand_op_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "nand_host_consts.svh"

module nand_op_decode #(
  parameter logic [2:0] FULL_ADDR_CYCLES = 3'h5
) (
  // Requested operation.
  input wire nand_host_pkg::op_type op,
  input wire logic intermediate,
  input wire logic [7:0] rawByte,
  // Framing of the operation on the bus.
  output logic [7:0] firstByte,
  output logic [2:0] addrStart,
  output logic [2:0] addrCount,
  output logic hasDataIn,
  output logic hasConfirm,
  output logic [7:0] confirmByte,
  output logic waitBusy,
  output logic hasDataOut,
  output logic modify
);

  // ----------------------------------------------------------------------
  // Per-operation framing table
  // ----------------------------------------------------------------------
  // Defaults describe a bare command; each branch adds only what differs.
  always_comb begin
    firstByte = rawByte;
    addrStart = `NAND_ADDR_ZERO;
    addrCount = `NAND_ADDR_ZERO;
    hasDataIn = 1'b0;
    hasConfirm = 1'b0;
    confirmByte = `NAND_OP_PROG_CONF;
    waitBusy = 1'b0;
    hasDataOut = 1'b0;
    modify = 1'b0;
    unique case (op)
      nand_host_pkg::OP_RESET: begin
        firstByte = `NAND_OP_RESET;
        waitBusy = 1'b1;
      end
      // Plain status has no address and may go to a busy die.
      nand_host_pkg::OP_STATUS: begin
        firstByte = `NAND_OP_STATUS;
        hasDataOut = 1'b1;
      end
      // Enhanced status selects a die by three row bytes.
      nand_host_pkg::OP_STATUS_ENH: begin
        firstByte = `NAND_OP_STATUS_ENH;
        addrStart = `NAND_ROW_START;
        addrCount = `NAND_ADDR_ROW;
        hasDataOut = 1'b1;
      end
      nand_host_pkg::OP_READ_ID: begin
        firstByte = `NAND_OP_READ_ID;
        addrCount = `NAND_ADDR_ONE;
        hasDataOut = 1'b1;
      end
      nand_host_pkg::OP_PARAM_PAGE, nand_host_pkg::OP_UNIQUE_ID: begin
        firstByte = (op == nand_host_pkg::OP_PARAM_PAGE) ?
          `NAND_OP_PARAM_PAGE : `NAND_OP_UNIQUE_ID;
        addrCount = `NAND_ADDR_ONE;
        waitBusy = 1'b1;
        hasDataOut = 1'b1;
      end
      nand_host_pkg::OP_GET_FEAT: begin
        firstByte = `NAND_OP_GET_FEAT;
        addrCount = `NAND_ADDR_ONE;
        waitBusy = 1'b1;
        hasDataOut = 1'b1;
      end
      nand_host_pkg::OP_SET_FEAT: begin
        firstByte = `NAND_OP_SET_FEAT;
        addrCount = `NAND_ADDR_ONE;
        hasDataIn = 1'b1;
        waitBusy = 1'b1;
      end
      // A bare read opcode returns the die to read mode, then reads out any requested bytes.
      nand_host_pkg::OP_READ_MODE: begin
        firstByte = `NAND_OP_READ;
        hasDataOut = 1'b1;
      end
      nand_host_pkg::OP_PAGE_READ, nand_host_pkg::OP_COPY_READ: begin
        firstByte = `NAND_OP_READ;
        addrCount = FULL_ADDR_CYCLES;
        hasConfirm = 1'b1;
        confirmByte = (op == nand_host_pkg::OP_PAGE_READ) ?
          `NAND_OP_READ_CONF : `NAND_OP_COPY_CONF;
        waitBusy = 1'b1;
        hasDataOut = (op == nand_host_pkg::OP_PAGE_READ);
      end
      nand_host_pkg::OP_RAND_OUT: begin
        firstByte = `NAND_OP_RAND_OUT;
        addrCount = `NAND_ADDR_COL;
        hasConfirm = 1'b1;
        confirmByte = `NAND_OP_RAND_OUT_CONF;
        hasDataOut = 1'b1;
      end
      nand_host_pkg::OP_RAND_IN: begin
        firstByte = `NAND_OP_RAND_IN;
        addrCount = `NAND_ADDR_COL;
        hasDataIn = 1'b1;
      end
      // The middle confirm lets a second plane be loaded before the
      // final one starts both planes together.
      nand_host_pkg::OP_PROGRAM, nand_host_pkg::OP_REPROGRAM,
      nand_host_pkg::OP_COPY_PROGRAM: begin
        firstByte = (op == nand_host_pkg::OP_PROGRAM) ? `NAND_OP_PROGRAM :
          (op == nand_host_pkg::OP_REPROGRAM) ? `NAND_OP_REPROGRAM :
          `NAND_OP_RAND_IN;
        addrCount = FULL_ADDR_CYCLES;
        hasDataIn = 1'b1;
        hasConfirm = 1'b1;
        confirmByte = intermediate ?
          `NAND_OP_PROG_MID : `NAND_OP_PROG_CONF;
        waitBusy = 1'b1;
        modify = 1'b1;
      end
      // A two-plane erase sends the first plane without confirm.
      nand_host_pkg::OP_ERASE: begin
        firstByte = `NAND_OP_ERASE;
        addrStart = `NAND_ROW_START;
        addrCount = `NAND_ADDR_ROW;
        hasConfirm = !intermediate;
        confirmByte = `NAND_OP_ERASE_CONF;
        waitBusy = !intermediate;
        modify = 1'b1;
      end
      // Multi-byte entry sequences are sent as single raw commands.
      nand_host_pkg::OP_RAW: begin
        firstByte = rawByte;
      end
      default: begin
        firstByte = rawByte;
      end
    endcase
  end

endmodule : nand_op_decode
`default_nettype wire

// >>> rtl/nand_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "nand_host_consts.svh"

module nand_host #(
  parameter logic [2:0] FULL_ADDR_CYCLES = 3'h5,
  parameter int LEN_WIDTH = 13
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Operation request.
  input wire logic opValid,
  output logic opReady,
  input wire nand_host_pkg::op_type opCode,
  input wire logic opIntermediate,
  input wire logic [7:0] opRawByte,
  input wire logic [11:0] opColumn,
  input wire logic [16:0] opRow,
  input wire logic [LEN_WIDTH-1:0] opLength,
  output logic opDone,
  // Bytes to program.
  input wire logic writeValid,
  output logic writeReady,
  input wire logic [7:0] writeData,
  // Bytes read back.
  output logic readValid,
  output logic [7:0] readData,
  // Flash pins.
  output logic selectN,
  output logic cmdLatch,
  output logic addrLatch,
  output logic writeStrobeN,
  output logic read_strobe_n,
  output logic writeProtectN,
  output logic [7:0] dqOut,
  output logic dqOe,
  input wire logic [7:0] dqIn,
  input wire logic readyBusyN
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [7:0] dqMeta; // First stage, read only by the second.
  logic [7:0] dqSync; // Data from the flash, safe to use.
  logic rbMeta; // First stage of the ready line.
  logic rbSync; // High while the die is ready.

  // Both pins come from the flash's own timing, so each passes two stages.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dqMeta <= 8'h00;
      dqSync <= 8'h00;
      rbMeta <= 1'b0;
      rbSync <= 1'b0;
    end else begin
      dqMeta <= dqIn;
      dqSync <= dqMeta;
      rbMeta <= readyBusyN;
      rbSync <= rbMeta;
    end
  end

  // ----------------------------------------------------------------------
  // Operation framing
  // ----------------------------------------------------------------------
  nand_host_pkg::op_type op; // Operation being run.
  logic mid; // Intermediate-confirm flavour of op.
  logic [7:0] raw; // Raw command byte.
  logic [7:0] firstByte;
  logic [2:0] addrStart;
  logic [2:0] addrCount;
  logic hasDataIn;
  logic hasConfirm;
  logic [7:0] confirmByte;
  logic waitBusy;
  logic hasDataOut;
  logic modify;

  nand_op_decode #(
    .FULL_ADDR_CYCLES(FULL_ADDR_CYCLES)
  ) i_nand_op_decode (
    .op(op),
    .intermediate(mid),
    .rawByte(raw),
    .firstByte(firstByte),
    .addrStart(addrStart),
    .addrCount(addrCount),
    .hasDataIn(hasDataIn),
    .hasConfirm(hasConfirm),
    .confirmByte(confirmByte),
    .waitBusy(waitBusy),
    .hasDataOut(hasDataOut),
    .modify(modify)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  nand_host_pkg::state_type state; // Current bus activity.
  logic [1:0] phase; // Position within one strobe cycle.
  logic [2:0] addrIndex; // Next address byte to send.
  logic [2:0] addrLeft; // Address bytes still to send.
  logic [LEN_WIDTH-1:0] bytesLeft; // Data bytes still to move.
  logic [11:0] column; // Column of the running operation.
  logic [16:0] row; // Page and block of the running operation.
  logic [7:0] turnCount; // Turnaround before busy or data out.
  logic [39:0] addrBytes; // Address bytes, column first.
  logic cycleEnd; // Last phase of a write strobe cycle.

  // Columns lead, then page bits with the block above them.
  assign addrBytes = {7'h00, row[16], row[15:8], row[7:0],
    4'h0, column[11:8], column[7:0]};
  assign cycleEnd = (phase == `NAND_PH_WE_HIGH);

  // Moves through command, address, data, confirm, wait and read-out.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= nand_host_pkg::ST_IDLE;
      phase <= 2'h0;
      op <= nand_host_pkg::OP_RESET;
      mid <= 1'b0;
      raw <= 8'h00;
      addrIndex <= 3'h0;
      addrLeft <= 3'h0;
      bytesLeft <= '0;
      column <= 12'h000;
      row <= 17'h0_0000;
      turnCount <= 8'h00;
    end else begin
      unique case (state)
        nand_host_pkg::ST_IDLE: begin
          phase <= `NAND_PH_SETUP;
          if (opValid && opReady) begin
            op <= opCode;
            mid <= opIntermediate;
            raw <= opRawByte;
            column <= opColumn;
            row <= opRow;
            bytesLeft <= (opCode == nand_host_pkg::OP_SET_FEAT) ?
              `NAND_FEATURE_BYTES : opLength;
            state <= nand_host_pkg::ST_CMD;
          end
        end
        nand_host_pkg::ST_CMD: begin
          phase <= phase + 2'h1;
          if (cycleEnd) begin
            addrIndex <= addrStart;
            addrLeft <= addrCount;
            state <= (addrCount != 3'h0) ? nand_host_pkg::ST_ADDR :
              (hasDataIn && bytesLeft != '0) ? nand_host_pkg::ST_DIN :
              hasConfirm ? nand_host_pkg::ST_CONF :
              nand_host_pkg::ST_TURN;
            turnCount <= 8'(`NAND_TURN_CYC);
          end
        end
        nand_host_pkg::ST_ADDR: begin
          phase <= phase + 2'h1;
          if (cycleEnd) begin
            addrIndex <= addrIndex + 3'h1;
            addrLeft <= addrLeft - 3'h1;
            if (addrLeft == 3'h1) begin
              state <= (hasDataIn && bytesLeft != '0) ?
                nand_host_pkg::ST_DIN : hasConfirm ?
                nand_host_pkg::ST_CONF : nand_host_pkg::ST_TURN;
            end
          end
        end
        nand_host_pkg::ST_DIN: begin
          // Phase 0 holds until the user supplies a byte.
          if (phase != `NAND_PH_SETUP || (writeValid && writeReady)) begin
            phase <= phase + 2'h1;
          end
          if (cycleEnd) begin
            bytesLeft <= bytesLeft - 1'b1;
            if (bytesLeft == 1) begin
              state <= hasConfirm ? nand_host_pkg::ST_CONF :
                nand_host_pkg::ST_TURN;
            end
          end
        end
        nand_host_pkg::ST_CONF: begin
          phase <= phase + 2'h1;
          if (cycleEnd) begin
            state <= nand_host_pkg::ST_TURN;
          end
        end
        // Busy may only show some time after the last strobe.
        nand_host_pkg::ST_TURN: begin
          phase <= `NAND_PH_SETUP;
          turnCount <= turnCount - 8'h01;
          if (turnCount <= 8'h01) begin
            state <= waitBusy ? nand_host_pkg::ST_WAIT :
              (hasDataOut && bytesLeft != '0) ? nand_host_pkg::ST_DOUT :
              nand_host_pkg::ST_IDLE;
          end
        end
        nand_host_pkg::ST_WAIT: begin
          if (rbSync) begin
            state <= (hasDataOut && bytesLeft != '0) ?
              nand_host_pkg::ST_DOUT : nand_host_pkg::ST_IDLE;
          end
        end
        nand_host_pkg::ST_DOUT: begin
          phase <= phase + 2'h1;
          if (phase == `NAND_PH_SAMPLE) begin
            bytesLeft <= bytesLeft - 1'b1;
            if (bytesLeft == 1) begin
              state <= nand_host_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------
  logic busCycle; // A write strobe cycle is in progress.
  assign busCycle = (state == nand_host_pkg::ST_CMD) ||
    (state == nand_host_pkg::ST_ADDR) || (state == nand_host_pkg::ST_CONF) ||
    (state == nand_host_pkg::ST_DIN && (phase != `NAND_PH_SETUP ||
    (writeValid && writeReady)));

  // Latch enables are set in phase 0 and held until the strobe rises.
  // The read strobe stays high in every state except read-out.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selectN <= 1'b1;
      cmdLatch <= 1'b0;
      addrLatch <= 1'b0;
      writeStrobeN <= 1'b1;
      read_strobe_n <= 1'b1;
      dqOut <= 8'h00;
      dqOe <= 1'b0;
    end else begin
      // Idle leaves the die deselected so it can drop to standby.
      selectN <= (state == nand_host_pkg::ST_IDLE) && !(opValid && opReady);
      if (state == nand_host_pkg::ST_IDLE) begin
        cmdLatch <= opValid && opReady;
        addrLatch <= 1'b0;
        dqOut <= 8'h00;
        dqOe <= 1'b0;
      end else if (busCycle && cycleEnd) begin
        // Set up the next cycle's latch enables; its byte is loaded below during its phase 0.
        cmdLatch <= (state == nand_host_pkg::ST_CMD && addrCount == 3'h0 &&
          !(hasDataIn && bytesLeft != '0) && hasConfirm) ||
          (state == nand_host_pkg::ST_ADDR && addrLeft == 3'h1 &&
          !(hasDataIn && bytesLeft != '0) && hasConfirm) ||
          (state == nand_host_pkg::ST_DIN && bytesLeft == 1 && hasConfirm);
        addrLatch <= (state == nand_host_pkg::ST_CMD && addrCount != 3'h0) ||
          (state == nand_host_pkg::ST_ADDR && addrLeft != 3'h1);
      end else if (!busCycle && state != nand_host_pkg::ST_DIN) begin
        cmdLatch <= 1'b0;
        addrLatch <= 1'b0;
      end
      // Data lanes carry the byte matching the state.
      unique case (state)
        nand_host_pkg::ST_CMD: dqOut <= firstByte;
        nand_host_pkg::ST_ADDR: dqOut <= addrBytes[{addrIndex, 3'b000} +: 8];
        nand_host_pkg::ST_CONF: dqOut <= confirmByte;
        nand_host_pkg::ST_DIN: begin
          if (phase == `NAND_PH_SETUP && writeValid && writeReady) begin
            dqOut <= writeData;
          end
        end
        default: begin
        end
      endcase
      // The lanes are driven from the cycle the command latch rises.
      dqOe <= busCycle ||
        (state == nand_host_pkg::ST_IDLE && opValid && opReady);
      // Write strobe low in phases 1 and 2, rising into phase 3.
      writeStrobeN <= !(busCycle && (phase == 2'h0 || phase == 2'h1) &&
        (phase != `NAND_PH_SETUP || state != nand_host_pkg::ST_DIN ||
        (writeValid && writeReady)));
      // Read strobe low for phases 1 to 3 of each output byte.
      read_strobe_n <= !(state == nand_host_pkg::ST_DOUT &&
        phase != `NAND_PH_SAMPLE);
    end
  end

  // Protection is lifted only for the length of a modify, set-features or random data-in operation.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeProtectN <= 1'b0;
    end else if (state == nand_host_pkg::ST_IDLE) begin
      writeProtectN <= opValid && opReady &&
        (opCode == nand_host_pkg::OP_PROGRAM ||
        opCode == nand_host_pkg::OP_REPROGRAM ||
        opCode == nand_host_pkg::OP_COPY_PROGRAM ||
        opCode == nand_host_pkg::OP_SET_FEAT ||
        opCode == nand_host_pkg::OP_RAND_IN ||
        opCode == nand_host_pkg::OP_ERASE);
    end
  end

  // ----------------------------------------------------------------------
  // User handshakes
  // ----------------------------------------------------------------------
  // Ready for a new operation only in idle, and not just after accepting.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opReady <= 1'b0;
      opDone <= 1'b0;
      writeReady <= 1'b0;
      readValid <= 1'b0;
      readData <= 8'h00;
    end else begin
      opReady <= (state == nand_host_pkg::ST_IDLE) && !(opValid && opReady);
      opDone <= (state != nand_host_pkg::ST_IDLE) &&
        (state != nand_host_pkg::ST_CMD) && (
        (state == nand_host_pkg::ST_TURN && turnCount <= 8'h01 && !waitBusy &&
        !(hasDataOut && bytesLeft != '0)) ||
        (state == nand_host_pkg::ST_WAIT && rbSync &&
        !(hasDataOut && bytesLeft != '0)) ||
        (state == nand_host_pkg::ST_DOUT && phase == `NAND_PH_SAMPLE &&
        bytesLeft == 1));
      // One byte is asked for at the start of every data-in cycle.
      writeReady <= (state == nand_host_pkg::ST_DIN) &&
        (phase == `NAND_PH_SETUP) && !(writeValid && writeReady);
      readValid <= (state == nand_host_pkg::ST_DOUT) &&
        (phase == `NAND_PH_SAMPLE);
      if (state == nand_host_pkg::ST_DOUT && phase == `NAND_PH_SAMPLE) begin
        readData <= dqSync;
      end
    end
  end

endmodule : nand_host
`default_nettype wire

// >>> test/nand_host_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Pin checks on the host side of the flash bus.
module nand_host_sva (
  // Clock, reset and watched outputs.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic readValid,
  input wire logic selectN,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic writeStrobeN,
  input wire logic read_strobe_n,
  input wire logic writeProtectN,
  input wire logic [7:0] dqOut,
  input wire logic dqOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cmd;
    cmdLatch |-> !addrLatch && !selectN && read_strobe_n && dqOe;
  endproperty
  a_cmd: assert property (p_cmd) else $error("cmd");
  property p_addr;
    addrLatch |-> !cmdLatch && !selectN && read_strobe_n && dqOe;
  endproperty
  a_addr: assert property (p_addr) else $error("addr");
  property p_we;
    $fell(writeStrobeN) |=> !writeStrobeN ##1 writeStrobeN;
  endproperty
  a_we: assert property (p_we) else $error("strobe");
  // The byte may change as the strobe falls, then must sit still.
  property p_hold;
    !writeStrobeN |-> dqOe ##1 $stable(dqOut);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_rd;
    !read_strobe_n |-> writeStrobeN && !cmdLatch && !addrLatch
      && !selectN && !dqOe;
  endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_rdlen;
    $fell(read_strobe_n) |-> !read_strobe_n[*3] ##1 read_strobe_n;
  endproperty
  a_rdlen: assert property (p_rdlen) else $error("rdlen");
  property p_rv;
    $fell(read_strobe_n) |-> ##[1:4] readValid;
  endproperty
  a_rv: assert property (p_rv) else $error("valid");
  property p_wp;
    cmdLatch && !writeStrobeN && dqOut inside {8'h80, 8'h60, 8'hD0}
      |-> writeProtectN;
  endproperty
  a_wp: assert property (p_wp) else $error("protect");
  c_read: cover property (readValid);
  c_erase: cover property (cmdLatch && dqOut == 8'hD0);
  c_addr: cover property (addrLatch && !writeStrobeN);
endmodule : nand_host_sva
`default_nettype wire

// >>> test/nand_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural die: latches on write strobe, answers on read strobe.
module nand_flash_model #(
  parameter logic [7:0] ID_BYTE = 8'h00 // Arbitrary value.
) (
  // Host pins.
  input wire logic selectN,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic writeStrobeN,
  input wire logic read_strobe_n,
  input wire logic writeProtectN,
  input wire logic [7:0] dqOut,
  input wire logic dqOe,
  // Die pins and array busy time.
  output logic [7:0] dqIn,
  output logic readyBusyN,
  input var int busyNs
);
  logic [7:0] mem [256]; // One page, low column byte.
  logic [7:0] feat [4]; // Feature bytes.
  logic [7:0] cmd = 8'hFF; // Last accepted opcode.
  logic [11:0] col = 12'h000; // Column pointer.
  int nAddr = 0;
  int nData = 0;
  initial begin
    readyBusyN = 1'b1;
    dqIn = 8'h00;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // A floating bus is never latched, so dqOe gates every capture.
  always @(posedge writeStrobeN) begin
    if (!selectN && read_strobe_n && dqOe) begin
      if (cmdLatch && !addrLatch) begin
        if (readyBusyN || dqOut inside {8'h70, 8'h78, 8'hFF}) begin
          cmd = dqOut;
          nAddr = 0;
          nData = 0;
          if (cmd inside {8'h10, 8'h11, 8'h30, 8'h35, 8'hD0,
              8'hFF}) begin
            readyBusyN <= 1'b0;
            readyBusyN <= #(busyNs) 1'b1;
          end
          if (cmd == 8'hD0 && writeProtectN) begin
            foreach (mem[i]) mem[i] = 8'hFF;
          end
        end
      end else if (addrLatch && !cmdLatch) begin
        if (nAddr == 0) col[7:0] = dqOut;
        if (nAddr == 1) col[11:8] = dqOut[3:0];
        nAddr++; // Row bytes, the fifth included, are ignored.
      end else if (!addrLatch && !cmdLatch && writeProtectN) begin
        if (cmd == 8'hEF) feat[nData[1:0]] = dqOut;
        else mem[col[7:0]] = dqOut;
        nData++;
        col++;
      end
    end
  end
  // A released bus shows the inverse of the last byte, not a held copy.
  always @(read_strobe_n or selectN) begin
    if (!selectN && !read_strobe_n && writeStrobeN && !cmdLatch
        && !addrLatch) begin
      case (cmd)
        8'h70, 8'h78: dqIn = {1'b0, readyBusyN, 6'h00};
        8'h90: dqIn = ID_BYTE;
        8'hEE: dqIn = feat[nData[1:0]];
        default: dqIn = mem[col[7:0]];
      endcase
      nData++;
      col++;
    end else begin
      dqIn = ~dqIn;
    end
  end
endmodule : nand_flash_model
`default_nettype wire

// >>> test/nand_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module nand_host_tb_top;
  localparam logic [7:0] idByte = 8'h5A; // Arbitrary value.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic opValid = 1'b0;
  logic opIntermediate = 1'b0;
  logic writeValid = 1'b0;
  logic [7:0] writeData = 8'h00;
  logic [7:0] opRawByte = 8'h00;
  logic [11:0] opColumn = 12'h000;
  logic [16:0] opRow = 17'h0_0000;
  logic [12:0] opLength = 13'h0000;
  nand_host_pkg::op_type opCode = nand_host_pkg::OP_RESET;
  logic opReady, opDone, writeReady, readValid, selectN, cmdLatch, dqOe;
  logic addrLatch, writeStrobeN, read_strobe_n, writeProtectN, readyBusyN;
  logic [7:0] readData, dqOut, dqIn;
  logic [7:0] sh [256]; // Expected array.
  logic [7:0] wq [$]; // Bytes to program.
  logic [7:0] got [$]; // Bytes read back.
  logic [7:0] otp [4] = '{8'h29, 8'h17, 8'h04, 8'h19};
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int busyNs = 300;
  int col, len;
  always #25 clk = ~clk;
  nand_host i_nand_host (.clk, .rst_n, .opValid, .opReady, .opCode,
    .opIntermediate, .opRawByte, .opColumn, .opRow, .opLength,
    .opDone, .writeValid, .writeReady, .writeData, .readValid, .readData,
    .selectN, .cmdLatch, .addrLatch, .writeStrobeN, .read_strobe_n,
    .writeProtectN, .dqOut, .dqOe, .dqIn, .readyBusyN);
  nand_flash_model #(.ID_BYTE(idByte)) i_nand_flash_model (.selectN,
    .cmdLatch, .addrLatch, .writeStrobeN, .read_strobe_n, .writeProtectN,
    .dqOut, .dqOe, .dqIn, .readyBusyN, .busyNs);
  // Each byte is held until taken; idle data is random.
  always @(posedge clk) begin
    if (writeValid && writeReady === 1'b1) void'(wq.pop_front());
    writeValid <= wq.size() > 0;
    writeData <= wq.size() > 0 ? wq[0] : 8'($urandom);
  end
  always @(posedge clk) if (readValid === 1'b1) got.push_back(readData);
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  // One request; the extra edge lets the last byte land in the queue.
  task automatic run(input nand_host_pkg::op_type op, input int n,
                     input logic [7:0] raw);
    got.delete();
    opCode <= op;
    opColumn <= col[11:0];
    opRow <= 17'($urandom);
    opLength <= n[12:0];
    opRawByte <= raw;
    opValid <= 1'b1;
    do @(posedge clk); while (opReady !== 1'b1);
    opValid <= 1'b0;
    for (int w = 0; w < 3000 && opDone !== 1'b1; w++) @(posedge clk);
    @(posedge clk);
  endtask : run
  initial begin
    void'($urandom(36));
    foreach (sh[i]) sh[i] = 8'hFF;
    col = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    run(nand_host_pkg::OP_RESET, 0, 8'h00);
    run(nand_host_pkg::OP_STATUS, 1, 8'h00);
    check(got[0], 8'h40);
    run(nand_host_pkg::OP_STATUS_ENH, 1, 8'h00);
    check(got[0], 8'h40);
    foreach (otp[i]) run(nand_host_pkg::OP_RAW, 0, otp[i]);
    // Slow and prompt busy, random and last columns, one to eight bytes.
    for (int k = 0; k < 4; k++) begin
      busyNs = k[0] ? 4000 : 300;
      col = k == 3 ? 248 : $urandom_range(200);
      len = k == 0 ? 1 : k == 3 ? 8 : $urandom_range(8, 1);
      for (int i = 0; i < len; i++) begin
        wq.push_back(8'($urandom));
        sh[col + i] = wq[$];
      end
      run(nand_host_pkg::OP_PROGRAM, len, 8'h00);
      run(nand_host_pkg::OP_PAGE_READ, len, 8'h00);
      for (int i = 0; i < len; i++) check(got[i], sh[col + i]);
      col = col + len - 1;
      run(nand_host_pkg::OP_RAND_OUT, 1, 8'h00);
      check(got[0], sh[col]);
    end
    col = 0;
    for (int i = 0; i < 4; i++) wq.push_back(8'($urandom));
    for (int i = 0; i < 4; i++) sh[i] = wq[i];
    run(nand_host_pkg::OP_SET_FEAT, 4, 8'h00);
    run(nand_host_pkg::OP_GET_FEAT, 4, 8'h00);
    for (int i = 0; i < 4; i++) check(got[i], sh[i]);
    run(nand_host_pkg::OP_READ_ID, 2, 8'h00);
    for (int i = 0; i < 2; i++) check(got[i], idByte);
    // Two-plane erase: the first half goes out without a confirm.
    opIntermediate <= 1'b1;
    run(nand_host_pkg::OP_ERASE, 0, 8'h00);
    opIntermediate <= 1'b0;
    run(nand_host_pkg::OP_ERASE, 0, 8'h00);
    col = 248;
    run(nand_host_pkg::OP_PAGE_READ, 8, 8'h00);
    for (int i = 0; i < 8; i++) check(got[i], 8'hFF);
    give_verdict();
  end
endmodule : nand_host_tb_top
bind nand_host nand_host_sva i_nand_host_sva (.clk, .rst_n, .readValid,
  .selectN, .cmdLatch, .addrLatch, .writeStrobeN, .read_strobe_n,
  .writeProtectN, .dqOut, .dqOe);
`default_nettype wire
